// ---- core/blseq_gap_timer.v ----
// minimum idle time of the lock pin between two sequences
`timescale 1ns/10ps
`include "blseq_consts.vh"
module blseq_gap_timer (
   input  wire       clock_i,
   input  wire       srst_i,
   input  wire       ce_i,
   input  wire       lock_fall_i,
   output wire       busy_o
);
   reg [1:0] gap_q;
   // load on release, count down to zero
   always @(posedge clock_i) begin
      if (srst_i) begin
         gap_q <= 2'h0;
      end else if (ce_i) begin
         if (lock_fall_i) gap_q <= `BLSEQ_GAP_CYCLES;
         else if (gap_q != 2'h0) gap_q <= gap_q - 2'h1;
      end
   end
   assign busy_o = (gap_q != 2'h0);
endmodule

// ---- core/blseq_insn_counter.v ----
// instruction counter that limits the length of a locked sequence
`timescale 1ns/10ps
`include "blseq_consts.vh"
module blseq_insn_counter #(
   parameter [4:0] LIMIT = `BLSEQ_MAX_INSNS
) (
   input  wire       clock_i,
   input  wire       srst_i,
   input  wire       ce_i,
   input  wire       run_i,
   input  wire       clear_i,
   input  wire       step_i,
   output reg        over_o
);
   reg [4:0] cnt_q;
   // count retired instructions while a sequence runs
   always @(posedge clock_i) begin
      if (srst_i) begin
         cnt_q  <= 5'h00;
         over_o <= 1'b0;
      end else if (ce_i) begin
         if (clear_i || !run_i) begin
            cnt_q  <= 5'h00;
            over_o <= 1'b0;
         end else if (step_i) begin
            if (cnt_q == LIMIT) over_o <= 1'b1; // limit exceeded
            else cnt_q <= cnt_q + 5'h01;
         end else begin
            over_o <= 1'b0;
         end
      end
   end
endmodule

// ---- core/blseq_top.v ----
// bus lock sequencer: lock pin, forced bus accesses, interrupt mask, length trap
//
// Overview of operation
// - after begin-lock the first data access issued to the bus drives the lock pin low.
// - external interrupts are masked from the next instruction until release.
// - after end-lock the next access, hit or miss, releases the pin and unmasks interrupts.
// - begin-lock and end-lock work at user and supervisor level alike.
// - in a sequence the first and all later accesses are forced to the bus.
// - the bus stays locked from the first bus access, or from the relock after a flag update, through the access after end-lock.
// - more than 30 instructions without release raise an instruction trap.
// - begin-lock while pending or held, and end-lock with no begin-lock, are ignored.
// - any trap taken inside the sequence sets the interlock flag.
// - the lock pin stays inactive at least one cycle between sequences.
// - the first access, if to an unaccessed page, locks briefly for the flag update, then relocks.
`timescale 1ns/10ps
`include "blseq_consts.vh"
module blseq_top (
   input  wire       clock_i,
   input  wire       srst_i,
   input  wire       ce_i,
   input  wire       insn_retire_i,
   input  wire       insn_lock_i,
   input  wire       insn_unlock_i,
   input  wire       user_mode_i,
   input  wire       mem_req_i,
   input  wire       cache_hit_i,
   input  wire       page_acc_i,
   input  wire       acc_upd_done_i,
   input  wire       mem_done_i,
   input  wire       trap_taken_i,
   input  wire       il_clear_i,
   output wire       force_bus_o,
   output wire       mem_stall_o,
   output reg        bus_lock_n_o,
   output wire       int_mask_o,
   output reg        insn_trap_o,
   output reg        interlock_flag_o
);
   localparam [2:0] ST_IDLE  = 3'd0; // no sequence
   localparam [2:0] ST_ARMED = 3'd1; // begin-lock seen, waiting for bus access
   localparam [2:0] ST_ACCUP = 3'd2; // brief lock for accessed-flag update
   localparam [2:0] ST_RELCK = 3'd3; // gap before relocking
   localparam [2:0] ST_HELD  = 3'd4; // bus locked
   localparam [2:0] ST_ENDNG = 3'd5; // end-lock seen, next access releases

   reg  [2:0] state_q;
   reg  [2:0] state_d;
   reg        lock_d;
   wire       gap_busy;
   wire       over;
   wire       in_seq;
   wire       lock_fall;
   wire       done_release;
   wire       start;

   // user_mode_i is deliberately unused: no privilege check applies
   assign start        = insn_retire_i && insn_lock_i && (state_q == ST_IDLE);
   assign in_seq       = (state_q != ST_IDLE);
   assign done_release = (state_q == ST_ENDNG) && mem_req_i && mem_done_i;
   // pin low now and released at the coming edge
   assign lock_fall    = !bus_lock_n_o && !lock_d;

   // accesses go to the bus whenever a sequence is armed or running
   assign force_bus_o = in_seq && mem_req_i;
   // hold the first locked access while the pin must stay idle
   assign mem_stall_o = mem_req_i && gap_busy &&
                        ((state_q == ST_ARMED) || (state_q == ST_RELCK));
   assign int_mask_o  = in_seq;

   // sequencer next state
   always @* begin
      state_d = state_q;
      lock_d  = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (start) state_d = ST_ARMED;
         end
         ST_ARMED: begin
            if (mem_req_i && !gap_busy) begin
               lock_d = 1'b1;
               if (!page_acc_i) state_d = ST_ACCUP;
               else state_d = ST_HELD;
            end
         end
         ST_ACCUP: begin
            lock_d = 1'b1;
            if (acc_upd_done_i) begin
               lock_d  = 1'b0;
               state_d = ST_RELCK;
            end
         end
         ST_RELCK: begin
            if (!gap_busy) begin
               lock_d  = 1'b1;
               state_d = ST_HELD;
            end
         end
         ST_HELD: begin
            lock_d = 1'b1;
            if (insn_retire_i && insn_unlock_i) state_d = ST_ENDNG;
         end
         ST_ENDNG: begin
            // keep the pin as it stands: an armed-only sequence never locks
            lock_d = !bus_lock_n_o;
            if (done_release) begin
               lock_d  = 1'b0;
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      // end-lock while only armed still ends with the next access
      if ((state_q == ST_ARMED) && insn_retire_i && insn_unlock_i && !mem_req_i) begin
         state_d = ST_ENDNG;
      end
      if (over) begin
         state_d = ST_IDLE;
         lock_d  = 1'b0;
      end
   end

   // state, pin and flag registers
   always @(posedge clock_i) begin
      if (srst_i) begin
         state_q          <= ST_IDLE;
         bus_lock_n_o     <= 1'b1;
         insn_trap_o      <= 1'b0;
         interlock_flag_o <= `BLSEQ_IL_RESET;
      end else if (ce_i) begin
         state_q      <= state_d;
         bus_lock_n_o <= !lock_d;
         insn_trap_o  <= over;
         // set wins over software clear
         if ((in_seq && trap_taken_i) || over) interlock_flag_o <= 1'b1;
         else if (il_clear_i) interlock_flag_o <= 1'b0;
      end
   end

   // length limit counter
   blseq_insn_counter #(
      .LIMIT (`BLSEQ_MAX_INSNS)
   ) u_cnt (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .ce_i    (ce_i),
      .run_i   (in_seq),
      .clear_i (done_release || over),
      .step_i  (insn_retire_i),
      .over_o  (over)
   );

   // idle gap after each release
   blseq_gap_timer u_gap (
      .clock_i     (clock_i),
      .srst_i      (srst_i),
      .ce_i        (ce_i),
      .lock_fall_i (lock_fall),
      .busy_o      (gap_busy)
   );
endmodule

// ---- pkg/blseq_consts.vh ----
// constants for the bus lock sequencer
`ifndef BLSEQ_CONSTS_VH
`define BLSEQ_CONSTS_VH
`define BLSEQ_MAX_INSNS     5'd30
`define BLSEQ_CNT_W         5
`define BLSEQ_GAP_CYCLES    2'd1
`define BLSEQ_IL_RESET      1'b0
`endif

// ---- verif/blseq_sva.sv ----
// checker for the bus lock sequencer ports
`timescale 1ns/10ps
module blseq_sva (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic insn_retire_i,
   input wire logic insn_lock_i,
   input wire logic mem_req_i,
   input wire logic force_bus_o,
   input wire logic bus_lock_n_o,
   input wire logic int_mask_o,
   input wire logic insn_trap_o,
   input wire logic interlock_flag_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   // a begin-lock accepted while idle
   sequence s_lock_taken;
      ce_i && insn_retire_i && insn_lock_i && !int_mask_o && bus_lock_n_o;
   endsequence
   a_mask_on_lock: assert property (s_lock_taken |=> int_mask_o)
      else $error("no mask after lock");
   a_lock_by_access: assert property ($fell(bus_lock_n_o) |-> $past(mem_req_i) && int_mask_o)
      else $error("lock without access");
   a_lock_in_seq: assert property (!bus_lock_n_o |-> int_mask_o)
      else $error("lock outside sequence");
   a_force_in_seq: assert property (mem_req_i && int_mask_o |-> force_bus_o)
      else $error("access not forced");
   a_release_unmask: assert property ($fell(int_mask_o) |-> bus_lock_n_o)
      else $error("unmask while locked");
   a_trap_pulse: assert property (insn_trap_o |=> !insn_trap_o && !int_mask_o)
      else $error("trap not one pulse");
   a_trap_flag: assert property (insn_trap_o |-> ##[0:1] interlock_flag_o)
      else $error("trap without flag");
   a_gap_idle: assert property ($rose(bus_lock_n_o) |=> bus_lock_n_o)
      else $error("relock without gap");
endmodule
bind blseq_top blseq_sva chk_u (.*);

// ---- verif/blseq_sys_model.sv ----
// system side model: answers accesses and flag updates
`timescale 1ns/10ps
module blseq_sys_model (
   input  wire logic clock_i,
   input  wire logic srst_i,
   input  wire logic slow_i,
   input  wire logic mem_req_i,
   input  wire logic mem_stall_i,
   input  wire logic page_acc_i,
   input  wire logic bus_lock_n_i,
   output reg        mem_done_o,
   output reg        acc_upd_done_o
);
   reg [1:0] cnt_q;
   reg [2:0] upd_q;
   // one done pulse per access, after 0 or 3 wait cycles
   always @(posedge clock_i) begin
      if (srst_i || !mem_req_i || mem_done_o) begin
         cnt_q <= 2'h0;
         mem_done_o <= 1'b0;
      end else if (!mem_stall_i && page_acc_i) begin
         cnt_q <= cnt_q + 2'h1;
         mem_done_o <= (cnt_q == {slow_i, slow_i});
      end
   end
   // location lock follows the pin; flag update reported once
   always @(posedge clock_i) begin
      upd_q <= srst_i ? 3'h0 : {upd_q[1:0], !bus_lock_n_i && !page_acc_i};
      acc_upd_done_o <= !srst_i && upd_q[1] && !upd_q[2];
   end
endmodule

// ---- verif/tb_top.sv ----
// testbench for the bus lock sequencer
`timescale 1ns/10ps
`define CHK(a,b) begin compares++; if ((a) !== (b)) begin errors++; $display("Error %0t bad", $time); end end
module tb_top;
   logic clock_i = 0, srst_i = 1, rt = 0, lk = 0, ul = 0, um = 0, rq = 0, hit = 0;
   logic pa = 1, tt = 0, ic = 0, sl = 0, seen = 0, lnp = 1, ce = 1, fbs = 0;
   wire  fb, st, ln, im, it, il, md, ad;
   int   errors = 0, compares = 0, ups = 0;
   always #10 clock_i = ~clock_i;
   blseq_top dut_u (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce), .insn_retire_i(rt),
      .insn_lock_i(lk), .insn_unlock_i(ul), .user_mode_i(um), .mem_req_i(rq), .cache_hit_i(hit),
      .page_acc_i(pa), .acc_upd_done_i(ad), .mem_done_i(md), .trap_taken_i(tt), .il_clear_i(ic),
      .force_bus_o(fb), .mem_stall_o(st), .bus_lock_n_o(ln), .int_mask_o(im), .insn_trap_o(it),
      .interlock_flag_o(il));
   blseq_sys_model sys_u (.clock_i(clock_i), .srst_i(srst_i), .slow_i(sl), .mem_req_i(rq),
      .mem_stall_i(st), .page_acc_i(pa), .bus_lock_n_i(ln), .mem_done_o(md), .acc_upd_done_o(ad));
   // trap pulses and brief releases inside a sequence
   always @(posedge clock_i) begin
      if (it === 1'b1) seen = 1;
      if (ln === 1'b1 && lnp === 1'b0 && im === 1'b1) ups++;
      lnp = ln;
   end
   task retire(input logic l, input logic u);
      @(negedge clock_i) {rt, lk, ul} = {1'b1, l, u};
      @(negedge clock_i) {rt, lk, ul} = 3'h0;
   endtask
   task access();
      @(negedge clock_i) rq = 1;
      // fbs keeps the forced-bus output as it stood at the completing edge
      do begin
         @(posedge clock_i);
         fbs = fb;
      end while (md !== 1'b1);
      @(negedge clock_i) rq = 0;
   endtask
   task t_basic();
      {um, hit, sl} = 3'h7;
      retire(1, 0);
      `CHK(im, 1'b1)
      access();
      `CHK({ln, fbs}, 2'h1)
      @(negedge clock_i) tt = 1;
      @(negedge clock_i) tt = 0;
      retire(0, 1);
      `CHK(ln, 1'b0)
      access();
      `CHK({ln, im, il}, 3'h5)
      ic = 1;
      @(negedge clock_i) ic = 0;
      `CHK(il, 1'b0)
   endtask
   task t_stray();
      {um, sl, ce} = 3'h0;
      retire(1, 0);
      ce = 1;
      `CHK(im, 1'b0)
      retire(0, 1);
      access();
      `CHK({ln, im, fbs}, 3'h4)
      retire(1, 0);
      retire(1, 0);
      access();
      retire(0, 1);
      access();
      `CHK({ln, im}, 2'h2)
      retire(1, 0);
      retire(0, 1);
      @(negedge clock_i);
      `CHK({ln, im}, 2'h3)
      access();
      `CHK({ln, im}, 2'h2)
   endtask
   task t_len();
      retire(1, 0);
      repeat (30) retire(0, 0);
      repeat (3) @(negedge clock_i);
      `CHK(seen, 1'b0)
      retire(0, 0);
      repeat (2) @(negedge clock_i);
      `CHK({seen, il, im, ln}, 4'hd)
   endtask
   task t_acc();
      pa = 0;
      retire(1, 0);
      {ups, rq} = {32'h0, 1'b1};
      do @(posedge clock_i); while (ad !== 1'b1);
      @(negedge clock_i) pa = 1;
      `CHK({fb, st}, 2'h3)
      access();
      `CHK(ln, 1'b0)
      `CHK(ups, 1)
      retire(0, 1);
      access();
      `CHK(ln, 1'b1)
   endtask
   task give_verdict();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      #100000;
      errors++;
      give_verdict();
   end
   initial begin
      repeat (10) @(posedge clock_i);
      @(negedge clock_i) srst_i = 0;
      t_basic();
      t_stray();
      t_len();
      t_acc();
      give_verdict();
   end
endmodule
